// [src/boot_strap_pkg.sv]
package boot_strap_pkg;

    // =====================================================================
    // apb register map
    // =====================================================================
    localparam int ADDR_W = 12;
    localparam int DATA_W = 32;
    localparam logic [ADDR_W-1:0] STRAP_VALUE_OFF = 12'h000;
    localparam logic [ADDR_W-1:0] BOOT_STATUS_OFF = 12'h004;
    localparam logic [ADDR_W-1:0] LOG_CTRL_OFF = 12'h008;

    // =====================================================================
    // strap bit layout (also the strap value register layout)
    // =====================================================================
    localparam int STRAP_W = 3;
    localparam int STRAP_A_BIT = 0;
    localparam int STRAP_B_BIT = 1;
    localparam int STRAP_C_BIT = 2;
    // pin c reads 1 through its pull-up when nobody drives it
    localparam logic [STRAP_W-1:0] STRAP_RESET_VAL = 3'h4;

    // =====================================================================
    // boot status register fields
    // =====================================================================
    localparam int ST_VALID_BIT = 0;
    localparam int ST_FLASH_BIT = 1;
    localparam int ST_DOWNLOAD_BIT = 2;
    localparam int ST_LOG_BIT = 3;
    localparam int ST_FUSE_LSB = 4;
    localparam int ST_RUNNING_BIT = 6;
    localparam int ST_RELEASED_BIT = 7;

    // log control register
    localparam int CTRL_MUTE_BIT = 0;
    localparam logic CTRL_MUTE_RESET = 1'b0;

    // =====================================================================
    // synchroniser lane layout
    // =====================================================================
    localparam int SY_W = 6;
    localparam int SY_EN = 0;
    localparam int SY_RST_N = 1;
    localparam int SY_PIN_A = 2;
    localparam int SY_PIN_B = 3;
    localparam int SY_PIN_C = 4;
    localparam int SY_PIN_C_OE = 5;

    // =====================================================================
    // types
    // =====================================================================
    typedef enum logic [1:0] {
        LOG_ALWAYS_ON = 2'h0,
        LOG_ON_WHEN_LOW = 2'h1,
        LOG_ON_WHEN_HIGH = 2'h2,
        LOG_ALWAYS_OFF = 2'h3
    } log_fuse_t;

    typedef enum logic [2:0] {
        PH_OFF = 3'b001,
        PH_CAPTURE = 3'b010,
        PH_RUN = 3'b100
    } phase_t;

endpackage : boot_strap_pkg

// [src/strap_sync.sv]
module strap_sync #(
    parameter int W = 1
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic [W-1:0] async_in,
    output logic [W-1:0] sync_out
);
    typedef struct packed {
        logic [W-1:0] first;
        logic [W-1:0] second;
    } sync_state_t;

    sync_state_t s_q;
    sync_state_t s_d;

    always_comb begin
        s_d = s_q;
        s_d.first = async_in;
        s_d.second = s_q.first;
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    assign sync_out = s_q.second;

endmodule : strap_sync

// [src/boot_strap_latch.sv]
// Behaviour
// (R1) run while chip enable is high; power off when it is low
// (R2) every system reset captures each strap pin as a 0 or 1 bit
// (R3) captured bits hold until power-down, whatever the pins do later
// (R4) pin c has a pull-up; undriven it captures as 1
// (R5) captured strap bits are readable by software in the strap value register
// (R6) after reset the pins are released and the bits stop tracking them
// (R7) flash boot: a=1,c=1; download boot: a=1,b=1,c=0
// (R8) fuse 0: rom log enabled regardless of strap b
// (R9) fuse 1: rom log enabled when b is 0, disabled when 1
// (R10) fuse 2: rom log disabled when b is 0, enabled when 1
// (R11) fuse 3: rom log disabled regardless of strap b
// (R12) the board sets straps by resistors or gpios during power-on
// (R13) capture loads throughout reset and freezes at reset release
//
// Design decisions made here: the APB interface to the registers and the placing of the registers.
module boot_strap_latch (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic [boot_strap_pkg::ADDR_W-1:0] paddr,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [boot_strap_pkg::DATA_W-1:0] pwdata,
    input wire logic [3:0] pstrb,
    output logic [boot_strap_pkg::DATA_W-1:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic chip_enable_pin,
    input wire logic system_reset_n,
    input wire logic strap_pin_a,
    input wire logic strap_pin_b,
    input wire logic strap_pin_c,
    input wire logic strap_pin_c_ext_oe,
    input wire boot_strap_pkg::log_fuse_t boot_log_fuse,
    output logic chip_running,
    output logic strap_pins_released,
    output logic boot_flash,
    output logic boot_download,
    output logic rom_log_enable
);
    import boot_strap_pkg::*;

    // =====================================================================
    // decode helpers
    // =====================================================================
    function automatic logic is_flash_boot(input logic [STRAP_W-1:0] s);
        is_flash_boot = s[STRAP_A_BIT] & s[STRAP_C_BIT];
    endfunction : is_flash_boot

    function automatic logic is_download_boot(input logic [STRAP_W-1:0] s);
        is_download_boot = s[STRAP_A_BIT] & s[STRAP_B_BIT] & ~s[STRAP_C_BIT];
    endfunction : is_download_boot

    function automatic logic rom_log_on(input log_fuse_t fuse, input logic b);
        logic on;
        on = 1'b1;
        unique case (fuse)
            // (R8) fuse 0 always on
            LOG_ALWAYS_ON: on = 1'b1;
            // (R9) fuse 1 on when low
            LOG_ON_WHEN_LOW: on = ~b;
            // (R10) fuse 2 on when high
            LOG_ON_WHEN_HIGH: on = b;
            // (R11) fuse 3 always off
            LOG_ALWAYS_OFF: on = 1'b0;
        endcase
        rom_log_on = on;
    endfunction : rom_log_on

    // =====================================================================
    // state
    // =====================================================================
    typedef struct packed {
        phase_t phase;
        logic [STRAP_W-1:0] straps;
        logic valid;
        logic mute;
        logic running;
        logic released;
        logic flash;
        logic download;
        logic log_en;
        logic pready;
        logic pslverr;
        logic [DATA_W-1:0] prdata;
    } state_t;

    localparam state_t STATE_RESET = '{
        phase: PH_OFF,
        straps: STRAP_RESET_VAL,
        valid: 1'b0,
        mute: CTRL_MUTE_RESET,
        running: 1'b0,
        released: 1'b0,
        flash: 1'b0,
        download: 1'b0,
        log_en: 1'b0,
        pready: 1'b0,
        pslverr: 1'b0,
        prdata: '0
    };

    state_t s_q;
    state_t s_d;
    logic [SY_W-1:0] sy;
    logic en;
    logic rst_act;
    logic [STRAP_W-1:0] pins;

    // =====================================================================
    // pin synchronisers
    // =====================================================================
    // every pin lane resets to 0: enable off and system reset active
    strap_sync #(
        .W(SY_W)
    ) u_sync (
        .pclk(pclk),
        .presetn(presetn),
        .async_in({strap_pin_c_ext_oe, strap_pin_c, strap_pin_b, strap_pin_a, system_reset_n, chip_enable_pin}),
        .sync_out(sy)
    );

    assign en = sy[SY_EN];
    assign rst_act = ~sy[SY_RST_N];
    // (R4) pull-up wins when undriven
    assign pins[STRAP_C_BIT] = sy[SY_PIN_C_OE] ? sy[SY_PIN_C] : 1'b1;
    assign pins[STRAP_B_BIT] = sy[SY_PIN_B];
    assign pins[STRAP_A_BIT] = sy[SY_PIN_A];

    // =====================================================================
    // next state
    // =====================================================================
    always_comb begin
        logic [DATA_W-1:0] status;
        logic [DATA_W-1:0] rdata;
        logic hit;
        status = '0;
        rdata = '0;
        hit = 1'b0;
        s_d = s_q;

        unique case (s_q.phase)
            PH_OFF: begin
                // (R1) powered down state
                s_d.straps = STRAP_RESET_VAL;
                s_d.valid = 1'b0;
                s_d.mute = CTRL_MUTE_RESET;
                if (en) begin
                    s_d.phase = PH_CAPTURE;
                end
            end
            PH_CAPTURE: begin
                if (!en) begin
                    s_d.phase = PH_OFF;
                end else if (rst_act) begin
                    // (R13) load while in reset
                    s_d.straps = pins;
                end else begin
                    // (R6) release pins, freeze bits
                    s_d.phase = PH_RUN;
                    s_d.valid = 1'b1;
                end
            end
            PH_RUN: begin
                // (R2) an active system reset recaptures
                if (!en) begin
                    s_d.phase = PH_OFF;
                end else if (rst_act) begin
                    s_d.phase = PH_CAPTURE;
                end
            end
            default: begin
                s_d.phase = PH_OFF;
            end
        endcase

        // (R1) power-off drops the running flag
        s_d.running = (s_d.phase != PH_OFF);
        s_d.released = (s_d.phase == PH_RUN);

        // =================================================================
        // apb slave: one wait state, answer registered
        // =================================================================
        status[ST_VALID_BIT] = s_q.valid;
        status[ST_FLASH_BIT] = s_q.flash;
        status[ST_DOWNLOAD_BIT] = s_q.download;
        status[ST_LOG_BIT] = s_q.log_en;
        status[ST_FUSE_LSB +: 2] = boot_log_fuse;
        status[ST_RUNNING_BIT] = s_q.running;
        status[ST_RELEASED_BIT] = s_q.released;

        unique case (paddr)
            // (R5) captured bits readable
            STRAP_VALUE_OFF: begin
                rdata[STRAP_W-1:0] = s_q.straps;
                hit = 1'b1;
            end
            BOOT_STATUS_OFF: begin
                rdata = status;
                hit = 1'b1;
            end
            LOG_CTRL_OFF: begin
                rdata[CTRL_MUTE_BIT] = s_q.mute;
                hit = 1'b1;
            end
            default: begin
                hit = 1'b0;
            end
        endcase

        s_d.pready = 1'b0;
        s_d.pslverr = 1'b0;
        if (psel && penable && !s_q.pready) begin
            s_d.pready = 1'b1;
            s_d.pslverr = ~hit;
            s_d.prdata = (hit && !pwrite) ? rdata : '0;
        end

        // writes land on the completing edge only
        if (psel && penable && s_q.pready && pwrite && pstrb[0] && paddr == LOG_CTRL_OFF &&
            s_q.phase != PH_OFF) begin
            s_d.mute = pwdata[CTRL_MUTE_BIT];
        end

        // (R1) clear on the edge that enters power-off, or stale boot outputs linger one cycle
        if (s_d.phase == PH_OFF) begin
            s_d.straps = STRAP_RESET_VAL;
            s_d.valid = 1'b0;
            s_d.mute = CTRL_MUTE_RESET;
        end

        // (R7) boot mode decode
        s_d.flash = s_d.valid & is_flash_boot(s_d.straps);
        s_d.download = s_d.valid & is_download_boot(s_d.straps);
        // mute only silences the log once software has booted
        s_d.log_en = s_d.valid & ~s_d.mute & rom_log_on(boot_log_fuse, s_d.straps[STRAP_B_BIT]);
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            s_q <= STATE_RESET;
        end else begin
            s_q <= s_d;
        end
    end

    assign prdata = s_q.prdata;
    assign pready = s_q.pready;
    assign pslverr = s_q.pslverr;
    assign chip_running = s_q.running;
    assign strap_pins_released = s_q.released;
    assign boot_flash = s_q.flash;
    assign boot_download = s_q.download;
    assign rom_log_enable = s_q.log_en;

    // =====================================================================
    // assertions
    // =====================================================================
    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);

    property p_off_when_disabled;
        !en |=> !chip_running && !strap_pins_released && !boot_flash && !rom_log_enable;
    endproperty
    a_off_when_disabled: assert property (p_off_when_disabled) else $error("running while enable low"); // (R1)

    property p_capture_in_reset;
        (s_q.phase == PH_CAPTURE && en && rst_act) |=> s_q.straps == $past(pins);
    endproperty
    a_capture_in_reset: assert property (p_capture_in_reset) else $error("strap not captured in reset"); // (R2)

    property p_hold_after_reset;
        (s_q.phase == PH_RUN && en && !rst_act) |=> $stable(s_q.straps) && s_q.valid;
    endproperty
    a_hold_after_reset: assert property (p_hold_after_reset) else $error("strap bits moved after capture"); // (R3)

    property p_pullup_c;
        (s_q.phase == PH_CAPTURE && en && rst_act && !sy[SY_PIN_C_OE]) |=> s_q.straps[STRAP_C_BIT];
    endproperty
    a_pullup_c: assert property (p_pullup_c) else $error("undriven pin c not read as 1"); // (R4)

    property p_strap_readback;
        (psel && penable && !pready && !pwrite && paddr == STRAP_VALUE_OFF)
            |=> pready && !pslverr && prdata[STRAP_W-1:0] == $past(s_q.straps);
    endproperty
    a_strap_readback: assert property (p_strap_readback) else $error("strap readback wrong"); // (R5)

    property p_release;
        (s_q.phase == PH_CAPTURE && en && !rst_act)
            |=> strap_pins_released ##1 (strap_pins_released || !en || rst_act);
    endproperty
    a_release: assert property (p_release) else $error("pins not released after reset"); // (R6)

    property p_boot_select;
        strap_pins_released |-> boot_flash == is_flash_boot(s_q.straps) &&
            boot_download == is_download_boot(s_q.straps) && !(boot_flash && boot_download);
    endproperty
    a_boot_select: assert property (p_boot_select) else $error("boot mode decode wrong"); // (R7)

    property p_log_fuse0;
        (s_q.valid && !s_q.mute && $past(boot_log_fuse) == LOG_ALWAYS_ON) |-> rom_log_enable;
    endproperty
    a_log_fuse0: assert property (p_log_fuse0) else $error("log off with fuse 0"); // (R8)

    property p_log_fuse1;
        (s_q.valid && !s_q.mute && $past(boot_log_fuse) == LOG_ON_WHEN_LOW)
            |-> rom_log_enable == !s_q.straps[STRAP_B_BIT];
    endproperty
    a_log_fuse1: assert property (p_log_fuse1) else $error("log wrong with fuse 1"); // (R9)

    property p_log_fuse2;
        (s_q.valid && !s_q.mute && $past(boot_log_fuse) == LOG_ON_WHEN_HIGH)
            |-> rom_log_enable == s_q.straps[STRAP_B_BIT];
    endproperty
    a_log_fuse2: assert property (p_log_fuse2) else $error("log wrong with fuse 2"); // (R10)

    property p_log_fuse3;
        ($past(boot_log_fuse) == LOG_ALWAYS_OFF) |-> !rom_log_enable;
    endproperty
    a_log_fuse3: assert property (p_log_fuse3) else $error("log on with fuse 3"); // (R11)

    sequence s_reset_release;
        (s_q.phase == PH_CAPTURE && en && rst_act) ##1 (s_q.phase == PH_CAPTURE && en && !rst_act);
    endsequence

    property p_freeze_at_release;
        s_reset_release |=> $stable(s_q.straps) && s_q.phase == PH_RUN;
    endproperty
    a_freeze_at_release: assert property (p_freeze_at_release) else $error("straps loaded at release"); // (R13)

    c_flash_boot: cover property (s_q.phase == PH_CAPTURE ##1 boot_flash);
    c_download_boot: cover property (s_q.phase == PH_CAPTURE ##1 boot_download);
    c_recapture: cover property (s_q.phase == PH_RUN ##1 s_q.phase == PH_CAPTURE ##[1:20] s_q.phase == PH_RUN);
    c_apb_error: cover property (pready && pslverr);

endmodule : boot_strap_latch

// [dv/strap_board.sv]
module strap_board (
    input wire logic pclk,
    output logic chip_enable_pin,
    output logic system_reset_n,
    output logic strap_pin_a,
    output logic strap_pin_b,
    output logic strap_pin_c,
    output logic strap_pin_c_ext_oe
);
    timeunit 1ns;
    timeprecision 1ps;

    logic c_val;
    logic c_drv;

    // =========================================================
    // pad level of pin c
    // =========================================================
    // pull-up wins undriven
    assign strap_pin_c = c_drv ? c_val : 1'b1;
    assign strap_pin_c_ext_oe = c_drv;

    initial begin
        chip_enable_pin = 1'b0;
        system_reset_n = 1'b0;
        strap_pin_a = 1'b0;
        strap_pin_b = 1'b0;
        c_val = 1'b0;
        c_drv = 1'b0;
    end

    // =========================================================
    // board actions
    // =========================================================
    // straps set during reset
    task automatic boot(input logic a, input logic b, input logic c, input logic drv);
        @(posedge pclk);
        chip_enable_pin <= 1'b1;
        system_reset_n <= 1'b0;
        strap_pin_a <= a;
        strap_pin_b <= b;
        c_val <= c;
        c_drv <= drv;
        repeat (6) @(posedge pclk);
        system_reset_n <= 1'b1;
        repeat (6) @(posedge pclk);
        // pins back in normal use; other levels expose any tracking
        strap_pin_a <= ~a;
        strap_pin_b <= ~b;
        c_val <= ~c;
        c_drv <= 1'b1;
        repeat (5) @(posedge pclk);
    endtask : boot

    task automatic power_off();
        @(posedge pclk);
        chip_enable_pin <= 1'b0;
        system_reset_n <= 1'b0;
        repeat (5) @(posedge pclk);
    endtask : power_off
endmodule : strap_board

// [dv/boot_strap_latch_bench.sv]
module boot_strap_latch_bench;
    timeunit 1ns;
    timeprecision 1ps;
    import boot_strap_pkg::*;

    logic pclk;
    logic presetn;
    logic [ADDR_W-1:0] paddr;
    logic psel;
    logic penable;
    logic pwrite;
    logic [DATA_W-1:0] pwdata;
    logic [3:0] pstrb;
    logic [DATA_W-1:0] prdata;
    logic pready;
    logic pslverr;
    logic chip_enable_pin;
    logic system_reset_n;
    logic strap_pin_a;
    logic strap_pin_b;
    logic strap_pin_c;
    logic strap_pin_c_ext_oe;
    log_fuse_t boot_log_fuse;
    logic chip_running;
    logic strap_pins_released;
    logic boot_flash;
    logic boot_download;
    logic rom_log_enable;
    logic [DATA_W-1:0] rd;
    logic er;
    int n_errors;
    int n_tests;

    boot_strap_latch dut (.pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel), .penable(penable),
        .pwrite(pwrite), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .chip_enable_pin(chip_enable_pin), .system_reset_n(system_reset_n), .strap_pin_a(strap_pin_a),
        .strap_pin_b(strap_pin_b), .strap_pin_c(strap_pin_c), .strap_pin_c_ext_oe(strap_pin_c_ext_oe),
        .boot_log_fuse(boot_log_fuse), .chip_running(chip_running), .strap_pins_released(strap_pins_released),
        .boot_flash(boot_flash), .boot_download(boot_download), .rom_log_enable(rom_log_enable));

    strap_board board (.pclk(pclk), .chip_enable_pin(chip_enable_pin), .system_reset_n(system_reset_n),
        .strap_pin_a(strap_pin_a), .strap_pin_b(strap_pin_b), .strap_pin_c(strap_pin_c),
        .strap_pin_c_ext_oe(strap_pin_c_ext_oe));

    initial begin
        pclk = 1'b0;
        forever #10 pclk = ~pclk;
    end

    // =========================================================
    // helpers
    // =========================================================
    task automatic end_sim();
        $display("checks %0d, mismatches %0d", n_tests, n_errors);
        if (n_errors == 0 && n_tests > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask : end_sim

    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
        n_tests++;
        if (got !== exp) begin
            n_errors++;
            $display("[ERR] %0t %s: got %h want %h", $time, what, got, exp);
        end
    endtask : chk

    // one apb transfer; bounded wait on pready
    task automatic apb(input logic wr, input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
        int k;
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        pstrb <= 4'hF;
        @(posedge pclk);
        penable <= 1'b1;
        k = 0;
        do begin
            @(posedge pclk);
            k++;
        end while (pready !== 1'b1 && k < 20);
        if (pready !== 1'b1) begin
            n_errors++;
            $display("[ERR] %0t apb answer missing", $time);
            end_sim();
        end
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    function automatic logic log_exp(input logic [1:0] f, input logic b);
        case (f)
            2'h0: return 1'b1;
            2'h1: return ~b;
            2'h2: return b;
            default: return 1'b0;
        endcase
    endfunction : log_exp

    // straps as captured, with the pins already moved away
    task automatic check_run(input logic a, input logic b, input logic c);
        logic fl;
        logic dl;
        logic lg;
        fl = a & c;
        dl = a & b & ~c;
        lg = log_exp(boot_log_fuse, b);
        apb(1'b0, STRAP_VALUE_OFF, 32'h0);
        chk(rd, {29'h0, c, b, a}, "strap value");
        apb(1'b0, BOOT_STATUS_OFF, 32'h0);
        chk(rd, {24'h0, 2'b11, boot_log_fuse, lg, dl, fl, 1'b1}, "boot status");
        chk({29'h0, boot_flash, boot_download, rom_log_enable}, {29'h0, fl, dl, lg}, "outputs");
        chk({31'h0, strap_pins_released}, 32'h1, "released");
    endtask : check_run

    // =========================================================
    // main sequence
    // =========================================================
    initial begin
        presetn = 1'b0;
        paddr = '0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        pwdata = '0;
        pstrb = 4'h0;
        boot_log_fuse = LOG_ALWAYS_ON;
        n_errors = 0;
        n_tests = 0;
        repeat (3) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        apb(1'b0, STRAP_VALUE_OFF, 32'h0);
        chk(rd, 32'h4, "strap default");
        chk({31'h0, chip_running}, 32'h0, "off at start");
        $display("test power_off_default done");

        for (int f = 0; f < 4; f++) begin
            for (int b = 0; b < 2; b++) begin
                boot_log_fuse <= log_fuse_t'(f[1:0]);
                board.boot(1'b1, b[0], 1'b1, 1'b1);
                check_run(1'b1, b[0], 1'b1);
            end
        end
        $display("test fuse_table done");

        board.boot(1'b1, 1'b1, 1'b0, 1'b1);
        check_run(1'b1, 1'b1, 1'b0);
        board.boot(1'b0, 1'b1, 1'b0, 1'b1);
        check_run(1'b0, 1'b1, 1'b0);
        board.boot(1'b1, 1'b0, 1'b0, 1'b0);
        check_run(1'b1, 1'b0, 1'b1);
        $display("test boot_modes done");

        // fuse 0 keeps the log on, so the mute has something to silence
        boot_log_fuse <= LOG_ALWAYS_ON;
        repeat (2) @(posedge pclk);
        chk({31'h0, rom_log_enable}, 32'h1, "log before mute");
        apb(1'b1, LOG_CTRL_OFF, 32'h1);
        repeat (2) @(posedge pclk);
        chk({31'h0, rom_log_enable}, 32'h0, "muted log");
        apb(1'b0, LOG_CTRL_OFF, 32'h0);
        chk(rd, 32'h1, "mute readback");
        apb(1'b1, STRAP_VALUE_OFF, 32'h0);
        chk({31'h0, er}, 32'h0, "ro write no error");
        apb(1'b0, STRAP_VALUE_OFF, 32'h0);
        chk(rd, 32'h5, "ro write ignored");
        apb(1'b0, 12'h00C, 32'h0);
        chk({er, rd[30:0]}, 32'h80000000, "unmapped");
        $display("test registers done");

        board.power_off();
        chk({30'h0, chip_running, boot_flash}, 32'h0, "powered off");
        apb(1'b0, STRAP_VALUE_OFF, 32'h0);
        chk(rd, 32'h4, "straps cleared");
        apb(1'b0, LOG_CTRL_OFF, 32'h0);
        chk(rd, 32'h0, "mute cleared");
        $display("test power_down done");
        end_sim();
    end
endmodule : boot_strap_latch_bench
